// [hdl/asms_pkg.sv]
// constants, register map and types of the scan mode sequencer
package asms_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ASMS_CTRL_OFF    = 8'h00;
  localparam logic [7:0] ASMS_SWTRIG_OFF  = 8'h04;
  localparam logic [7:0] ASMS_TRGEN_OFF   = 8'h08;
  localparam logic [7:0] ASMS_STATUS_OFF  = 8'h0C;
  localparam logic [7:0] ASMS_DELAY_BASE  = 8'h40;
  localparam logic [7:0] ASMS_MASK_BASE   = 8'h80;
  localparam logic [7:0] ASMS_RESULT_BASE = 8'hC0;
  // ----------------------------------------------------------------
  // control and status field positions and reset values
  // ----------------------------------------------------------------
  localparam int ASMS_CTRL_METHOD_LSB = 0;
  localparam int ASMS_CTRL_RES_LSB    = 2;
  localparam int ASMS_CTRL_SMODE_LSB  = 4;
  localparam int ASMS_CTRL_STOP_BIT   = 8;
  localparam int ASMS_STAT_GRP_LSB    = 4;
  localparam int ASMS_STAT_VCH_LSB    = 8;
  localparam int ASMS_STAT_STOP_BIT   = 12;
  localparam int ASMS_STAT_PEND_LSB   = 16;
  localparam logic [1:0] ASMS_METHOD_RST = 2'h0;
  localparam logic [1:0] ASMS_RES_RST    = 2'h1;
  localparam logic [1:0] ASMS_SMODE_RST  = 2'h0;
  // ----------------------------------------------------------------
  // channel limits and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] ASMS_STD_MAX_VCH = 4'h8;
  localparam logic [3:0] ASMS_HYB_MAX_VCH = 4'h4;
  localparam int ASMS_CLK_MHZ = 100;
  localparam int ASMS_TRIG_GAP_CLK = 8;
  localparam logic [8:0] ASMS_TRIG_GAP_CYC = 9'(ASMS_TRIG_GAP_CLK * ASMS_CLK_MHZ / 100);
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASMS_SAR = 2'h0,
    ASMS_OVS = 2'h1,
    ASMS_HYB = 2'h2
  } asms_method_type;
  typedef enum logic [1:0] {
    ASMS_RES10 = 2'h0,
    ASMS_RES12 = 2'h1,
    ASMS_RES14 = 2'h2,
    ASMS_RES16 = 2'h3
  } asms_res_type;
  typedef enum logic [1:0] {
    ASMS_SINGLE = 2'h0,
    ASMS_CONT   = 2'h1,
    ASMS_BGCONT = 2'h2
  } asms_smode_type;
  typedef enum logic [1:0] {
    ASMS_IDLE  = 2'b00,
    ASMS_NEXT  = 2'b01,
    ASMS_START = 2'b11,
    ASMS_WAIT  = 2'b10
  } asms_state_type;
endpackage : asms_pkg

// [hdl/asms_top.sv]
// scan mode sequencer with apb register file
// Operation
// - exactly one of three conversion methods
// - sar offers 10 and 12 bit results
// - eight channels per group, four in hybrid
// - sar 14/16 bit widened to 16 bits
// - oversampling and hybrid offer all four resolutions
// - background triggers closer than 8+delay ignored
// - background scan only in hybrid method
// - simultaneous groups: lowest number scans first
// - channels converted in ascending virtual order
// - single scan converts group once per trigger
// - continuous scan repeats until stop
// - background scan starts on first trigger
// - later triggers publish data, otherwise unchanged
// - hardware starts delayed, software not; delayed hardware triggers publish at once and again after delay
`timescale 1ns/10ps
`default_nettype none
module asms_top
  import asms_pkg::*;
#(
  parameter int NUM_GROUPS = 9,
  parameter int NUM_VCH    = 8
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // start triggers
  input  wire logic [NUM_GROUPS-1:0] periph_trig,
  input  wire logic                  ext_trig_n,
  // converter core
  output logic                       conv_start,
  output logic      [2:0]            conv_vch,
  output logic      [1:0]            conv_method,
  input  wire logic                  conv_done,
  input  wire logic [15:0]           conv_data,
  // scan status
  output logic                       scan_active,
  output logic      [3:0]            scan_group,
  output logic                       publish
);
  localparam int GW = 4;
  localparam int VW = 3;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [GW-1:0] lowest(input logic [NUM_GROUPS-1:0] v);
    logic [GW-1:0] r;
    r = '0;
    for (int i = NUM_GROUPS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = GW'(i);
      end
    end
    return r;
  endfunction : lowest

  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [1:0] r,
                                      input logic [15:0] d);
    logic [15:0] o;
    o = '0;
    if (m == ASMS_OVS || m == ASMS_HYB) begin
      case (r)
        ASMS_RES10: o = {6'h00, d[15:6]};
        ASMS_RES12: o = {4'h0, d[15:4]};
        ASMS_RES14: o = {2'h0, d[15:2]};
        default:    o = d;
      endcase
    end else begin
      case (r)
        ASMS_RES10: o = {6'h00, d[15:6]};
        ASMS_RES12: o = {4'h0, d[15:4]};
        default:    o = {d[15:4], 4'h0};
      endcase
    end
    return o;
  endfunction : fmt

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]            method_q, res_q, smode_q;
  logic [NUM_GROUPS-1:0] trgen_q, pend_q, dly_act_q;
  logic [7:0]            dly_q     [NUM_GROUPS];
  logic [7:0]            dly_cnt_q [NUM_GROUPS];
  logic [NUM_VCH-1:0]    mask_q    [NUM_GROUPS];
  logic [15:0]           result_q  [NUM_VCH];
  logic [15:0]           shadow_q  [NUM_VCH];
  logic [31:0]           prdata_q;
  logic                  pready_q, pslverr_q, stop_q, conv_start_q, publish_q;
  logic                  ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q, ext_fall_q;
  logic [8:0]            guard_q;
  logic [GW-1:0]         grp_q;
  logic [VW-1:0]         vch_q;
  logic [3:0]            cnt_q;
  asms_state_type        state_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire             apb_acc  = psel & penable;
  wire             apb_wr   = apb_acc & pready_q & pwrite;
  wire [7:0]       a        = paddr[7:0];
  wire [7:0]       dly_off  = a - ASMS_DELAY_BASE;
  wire [7:0]       msk_off  = a - ASMS_MASK_BASE;
  wire [7:0]       res_off  = a - ASMS_RESULT_BASE;
  wire [GW-1:0]    dly_idx  = dly_off[5:2];
  wire [GW-1:0]    msk_idx  = msk_off[5:2];
  wire [VW-1:0]    res_idx  = res_off[4:2];
  wire             hi_zero  = (paddr[11:8] == 4'h0);
  wire             hit_ctrl = hi_zero & (a[7:2] == ASMS_CTRL_OFF[7:2]);
  wire             hit_sw   = hi_zero & (a[7:2] == ASMS_SWTRIG_OFF[7:2]);
  wire             hit_ten  = hi_zero & (a[7:2] == ASMS_TRGEN_OFF[7:2]);
  wire             hit_stat = hi_zero & (a[7:2] == ASMS_STATUS_OFF[7:2]);
  wire             hit_dly  = hi_zero & (dly_off[7:6] == 2'h0) & (dly_off[5:2] < 4'(NUM_GROUPS));
  wire             hit_msk  = hi_zero & (msk_off[7:6] == 2'h0) & (msk_off[5:2] < 4'(NUM_GROUPS));
  wire             hit_res  = hi_zero & (res_off[7:6] == 2'h0) & (res_off[5:2] < 4'(NUM_VCH));
  wire             hit_any  = hit_ctrl | hit_sw | hit_ten | hit_stat | hit_dly | hit_msk | hit_res;
  wire [31:0]      stat_w   = (32'(pend_q) << ASMS_STAT_PEND_LSB)
                            | (32'(stop_q) << ASMS_STAT_STOP_BIT)
                            | (32'(vch_q) << ASMS_STAT_VCH_LSB)
                            | (32'(grp_q) << ASMS_STAT_GRP_LSB)
                            | 32'(state_q != ASMS_IDLE);
  wire [31:0]      ctrl_w   = (32'(smode_q) << ASMS_CTRL_SMODE_LSB)
                            | (32'(res_q) << ASMS_CTRL_RES_LSB)
                            | (32'(method_q) << ASMS_CTRL_METHOD_LSB);
  wire [31:0]      rd_w     = hit_ctrl ? ctrl_w :
                              hit_ten  ? 32'(trgen_q) :
                              hit_stat ? stat_w :
                              hit_dly  ? 32'(dly_q[dly_idx]) :
                              hit_msk  ? 32'(mask_q[msk_idx]) :
                              hit_res  ? 32'(result_q[res_idx]) : 32'h0000_0000;
  wire             stop_wr  = apb_wr & hit_ctrl & pwdata[ASMS_CTRL_STOP_BIT];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [1:0]       wr_meth  = pwdata[ASMS_CTRL_METHOD_LSB +: 2];
  wire [1:0]       meth_d   = (wr_meth == 2'h3) ? ASMS_SAR : wr_meth;
  wire [1:0]       wr_mode  = pwdata[ASMS_CTRL_SMODE_LSB +: 2];
  wire [1:0]       smode_d  = (wr_mode == ASMS_BGCONT && meth_d != ASMS_HYB) ? ASMS_CONT :
                              (wr_mode == 2'h3) ? ASMS_SINGLE : wr_mode;
  wire             hyb      = (method_q == ASMS_HYB);
  wire             bg_mode  = hyb & (smode_q == ASMS_BGCONT);
  wire             running  = (state_q != ASMS_IDLE);
  wire [3:0]       limit    = hyb ? ASMS_HYB_MAX_VCH : ASMS_STD_MAX_VCH;
  wire             vch_last = (vch_q == VW'(NUM_VCH - 1));

  // ----------------------------------------------------------------
  // triggers
  // ----------------------------------------------------------------
  logic [NUM_GROUPS-1:0] sw_acc, hw_acc, fire, pend_set, pub_hit;
  wire             guard_ok = ~bg_mode | (guard_q == 9'h000);
  wire [GW-1:0]    acc_idx  = lowest(sw_acc | hw_acc);
  wire             any_acc  = |(sw_acc | hw_acc);
  wire [NUM_GROUPS-1:0] take = (state_q == ASMS_IDLE && |pend_q) ?
                               (NUM_GROUPS'(1) << lowest(pend_q)) : '0;

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_trig
      assign sw_acc[g]   = apb_wr & hit_sw & pwdata[g] & guard_ok;
      assign hw_acc[g]   = trgen_q[g] & (periph_trig[g] | ext_fall_q)
                         & guard_ok & ~dly_act_q[g];
      assign fire[g]     = dly_act_q[g] & (dly_cnt_q[g] == 8'h01);
      assign pub_hit[g]  = bg_mode & running & (grp_q == GW'(g));
      assign pend_set[g] = (sw_acc[g] | (hw_acc[g] & (dly_q[g] == 8'h00)) | fire[g])
                         & ~pub_hit[g];

      // a hardware start waits its delay in sys_clk cycles
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          dly_act_q[g] <= 1'b0;
          dly_cnt_q[g] <= 8'h00;
        end else if (hw_acc[g] && dly_q[g] != 8'h00) begin
          dly_act_q[g] <= 1'b1;
          dly_cnt_q[g] <= dly_q[g];
        end else if (dly_act_q[g]) begin
          dly_act_q[g] <= ~fire[g];
          dly_cnt_q[g] <= dly_cnt_q[g] - 8'h01;
        end
      end

      // the new trigger wins over the take and over a stop
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          pend_q[g] <= 1'b0;
        end else begin
          pend_q[g] <= pend_set[g] | (pend_q[g] & ~take[g] & ~stop_wr);
        end
      end
    end
  endgenerate

  wire             pub_now  = |((sw_acc | (hw_acc & ~dly_act_q) | fire) & pub_hit);

  // ----------------------------------------------------------------
  // external trigger pin, active low
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ext_s1_q   <= 1'b1;
      ext_s2_q   <= 1'b1;
      ext_s3_q   <= 1'b1;
      ext_lvl_q  <= 1'b1;
      ext_fall_q <= 1'b0;
    end else begin
      ext_s1_q   <= ext_trig_n;
      ext_s2_q   <= ext_s1_q;
      ext_s3_q   <= ext_s2_q;
      ext_lvl_q  <= (ext_s2_q == ext_s3_q) ? ext_s3_q : ext_lvl_q;
      ext_fall_q <= ext_lvl_q & (ext_s2_q == ext_s3_q) & ~ext_s3_q;
    end
  end

  // spacing guard; covers only background scanning
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      guard_q <= 9'h000;
    end else if (bg_mode && any_acc) begin
      guard_q <= ASMS_TRIG_GAP_CYC - 9'h001 + 9'(|sw_acc ? 8'h00 : dly_q[acc_idx]);
    end else if (guard_q != 9'h000) begin
      guard_q <= guard_q - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~hit_any;
      prdata_q  <= (apb_acc & ~pready_q & ~pwrite) ? rd_w : prdata_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      method_q <= ASMS_METHOD_RST;
      res_q    <= ASMS_RES_RST;
      smode_q  <= ASMS_SMODE_RST;
      trgen_q  <= '0;
    end else if (apb_wr && hit_ctrl) begin
      method_q <= meth_d;
      res_q    <= pwdata[ASMS_CTRL_RES_LSB +: 2];
      smode_q  <= smode_d;
    end else if (apb_wr && hit_ten) begin
      trgen_q  <= pwdata[NUM_GROUPS-1:0];
    end
  end

  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_cfg
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          dly_q[g]  <= 8'h00;
          mask_q[g] <= '0;
        end else begin
          if (apb_wr && hit_dly && dly_idx == GW'(g)) begin
            dly_q[g] <= pwdata[7:0];
          end
          if (apb_wr && hit_msk && msk_idx == GW'(g)) begin
            mask_q[g] <= pwdata[NUM_VCH-1:0];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------
  wire             store    = (state_q == ASMS_WAIT) & conv_done;
  wire [15:0]      conv_w   = fmt(method_q, res_q, conv_data);

  generate
    for (g = 0; g < NUM_VCH; g++) begin : g_res
      wire hit = store & (vch_q == VW'(g));
      // background data stays hidden until a trigger publishes it
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          result_q[g] <= 16'h0000;
          shadow_q[g] <= 16'h0000;
        end else begin
          shadow_q[g] <= (hit && bg_mode) ? conv_w : shadow_q[g];
          result_q[g] <= pub_now ? shadow_q[g] :
                         (hit && !bg_mode) ? conv_w : result_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // scan sequencer
  // ----------------------------------------------------------------
  wire             conv_ok  = mask_q[grp_q][vch_q] & (cnt_q < limit);
  wire             rescan   = ~stop_q & ~stop_wr & (smode_q != ASMS_SINGLE);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ASMS_IDLE;
      grp_q   <= '0;
      vch_q   <= '0;
      cnt_q   <= 4'h0;
      stop_q  <= 1'b0;
    end else begin
      stop_q <= running & (stop_q | stop_wr);
      case (state_q)
        ASMS_IDLE: begin
          if (|pend_q) begin
            grp_q   <= lowest(pend_q);
            vch_q   <= '0;
            cnt_q   <= 4'h0;
            state_q <= ASMS_NEXT;
          end
        end
        ASMS_NEXT: begin
          if (conv_ok) begin
            state_q <= ASMS_START;
          end else if (!vch_last) begin
            vch_q   <= vch_q + VW'(1);
          end else begin
            vch_q   <= '0;
            cnt_q   <= 4'h0;
            state_q <= rescan ? ASMS_NEXT : ASMS_IDLE;
          end
        end
        ASMS_START: begin
          state_q <= ASMS_WAIT;
        end
        ASMS_WAIT: begin
          if (conv_done) begin
            cnt_q <= cnt_q + 4'h1;
            if (!vch_last) begin
              vch_q   <= vch_q + VW'(1);
              state_q <= ASMS_NEXT;
            end else begin
              vch_q   <= '0;
              cnt_q   <= 4'h0;
              state_q <= rescan ? ASMS_NEXT : ASMS_IDLE;
            end
          end
        end
        default: begin
          state_q <= ASMS_IDLE;
        end
      endcase
    end
  end

  // converter strobes; a stop never cuts a conversion short
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conv_start_q <= 1'b0;
      publish_q    <= 1'b0;
    end else begin
      conv_start_q <= (state_q == ASMS_NEXT) & conv_ok;
      publish_q    <= pub_now;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign conv_start  = conv_start_q;
  assign conv_vch    = vch_q;
  assign conv_method = method_q;
  assign scan_active = (state_q != ASMS_IDLE);
  assign scan_group  = grp_q;
  assign publish     = publish_q;
endmodule : asms_top
`default_nettype wire

// [verification/asms_conv_model.sv]
// converter core model answering each conversion start
`timescale 1ns/10ps
`default_nettype none
module asms_conv_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // converter side
  input  wire logic        conv_start,
  input  wire logic [2:0]  conv_vch,
  input  wire logic [7:0]  lat,
  output var  logic        conv_done,
  output var  logic [15:0] conv_data,
  // record of converted channels
  output var  int          n_conv,
  output var  logic [2:0]  log_q [64]
);
  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;
  logic       busy_q;
  logic [2:0] vch_q;
  logic       noise_q;
  // data toggles outside a result so a stale sample never matches
  assign conv_data = conv_done ? {vch_q, 13'h1A5B} : {16{noise_q}};
  always_ff @(posedge sys_clk) begin
    noise_q   <= ~noise_q;
    conv_done <= 1'b0;
    if (!resetn) begin
      busy_q  <= 1'b0;
      noise_q <= 1'b0;
      n_conv  <= 0;
    end else if (conv_start) begin
      busy_q             <= 1'b1;
      cnt_q              <= lat;
      vch_q              <= conv_vch;
      log_q[n_conv[5:0]] <= conv_vch;
      n_conv             <= n_conv + 1;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q    <= 1'b0;
      conv_done <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : asms_conv_model
`default_nettype wire

// [verification/asms_monitor.sv]
// port checker of the scan mode sequencer
`timescale 1ns/10ps
`default_nettype none
module asms_monitor
  import asms_pkg::*;
#(
  parameter int NUM_GROUPS = 9,
  parameter int NUM_VCH    = 8
) (
  // clock, reset and apb
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // triggers, converter and status
  input wire logic [NUM_GROUPS-1:0] periph_trig,
  input wire logic                  ext_trig_n,
  input wire logic                  conv_start,
  input wire logic [2:0]            conv_vch,
  input wire logic [1:0]            conv_method,
  input wire logic                  conv_done,
  input wire logic [15:0]           conv_data,
  input wire logic                  scan_active,
  input wire logic [3:0]            scan_group,
  input wire logic                  publish
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic wait_q;
  // open from the cycle after conv_start up to and including its conv_done cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) wait_q <= 1'b0;
    else if (conv_start) wait_q <= 1'b1;
    else if (conv_done) wait_q <= 1'b0;
  end
  sequence sw_commit;
    psel && penable && pready && pwrite && paddr == 12'h004 && pwdata[8:0] != 9'h000
      && !scan_active;
  endsequence
  sequence scan_up;
    ##[1:4] scan_active;
  endsequence
  a_method_legal: assert property (conv_method != 2'h3)
    else $error("conversion method out of range");
  a_method_held: assert property (scan_active && $past(scan_active) |-> $stable(conv_method))
    else $error("method changed during a scan");
  a_vch_stable: assert property (wait_q |-> $stable(conv_vch))
    else $error("channel moved during a conversion");
  a_start_waits: assert property (wait_q |-> !conv_start)
    else $error("start before previous conversion ended");
  a_start_in_scan: assert property (conv_start |-> scan_active)
    else $error("start outside a scan");
  a_sw_undelayed: assert property (sw_commit |-> scan_up)
    else $error("software start was delayed");
  a_publish_pulse: assert property (publish |=> !publish)
    else $error("publish longer than one cycle");
  a_publish_hybrid: assert property (publish |-> conv_method == 2'h2)
    else $error("publish outside hybrid method");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule : asms_monitor
bind asms_top asms_monitor #(.NUM_GROUPS(NUM_GROUPS), .NUM_VCH(NUM_VCH)) u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_trig(periph_trig), .ext_trig_n(ext_trig_n), .conv_start(conv_start),
  .conv_vch(conv_vch), .conv_method(conv_method), .conv_done(conv_done),
  .conv_data(conv_data), .scan_active(scan_active), .scan_group(scan_group),
  .publish(publish)
);
`default_nettype wire

// [verification/asms_top_tb.sv]
// self-checking bench of the scan mode sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module asms_top_tb;
  import asms_pkg::*;
  logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, old;
  logic [8:0]  periph_trig = 9'h000;
  logic        ext_trig_n = 1'b1, err, pready, pslverr, conv_start, conv_done;
  logic        scan_active, publish;
  logic [2:0]  conv_vch;
  logic [1:0]  conv_method;
  logic [3:0]  scan_group;
  logic [15:0] conv_data;
  logic [7:0]  lat = 8'h10, mk;
  logic [2:0]  log_q [64];
  int          n_conv, error_cnt = 0, samples_checked = 0, pub_cnt = 0, i, c, m, r, t, p;
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  asms_top #(.NUM_GROUPS(9), .NUM_VCH(8)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_trig(periph_trig), .ext_trig_n(ext_trig_n), .conv_start(conv_start),
    .conv_vch(conv_vch), .conv_method(conv_method), .conv_done(conv_done),
    .conv_data(conv_data), .scan_active(scan_active), .scan_group(scan_group),
    .publish(publish)
  );
  asms_conv_model u_conv (
    .sys_clk(sys_clk), .resetn(resetn), .conv_start(conv_start), .conv_vch(conv_vch),
    .lat(lat), .conv_done(conv_done), .conv_data(conv_data), .n_conv(n_conv), .log_q(log_q)
  );
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (publish === 1'b1) pub_cnt++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] fx(input int fm, input int fr, input logic [15:0] d);
    if (fm == 0 && fr > 1) return {d[15:4], 4'h0};
    return d >> (6 - 2 * fr);
  endfunction : fx
  task automatic print_verdict();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic fail_wait();
    error_cnt++;
    $display("[ERR] wait exp done got bound");
    print_verdict();
  endtask : fail_wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) fail_wait();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  // idle set: also wait for the scan to end
  task automatic wt(input int n, input logic idle);
    int k;
    for (k = 0; k < 3000; k++) begin
      if (n_conv >= n && (!idle || scan_active === 1'b0)) return;
      @(posedge sys_clk);
    end
    fail_wait();
  endtask : wt
  task automatic pulse(input int g);
    periph_trig[g] <= 1'b1;
    @(posedge sys_clk);
    periph_trig <= 9'h000;
  endtask : pulse
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl reset", 32'h4, rd)
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 12'h080, 32'h1);
    for (m = 0; m < 2; m++) begin
      for (r = 0; r < 4; r++) begin
        apb(1'b1, 12'h000, 32'(m + 4 * r));
        t = n_conv;
        apb(1'b1, 12'h004, 32'h1);
        wt(t + 1, 1'b1);
        apb(1'b0, 12'h0C0, 32'h0);
        `CHK("format", {16'h0, fx(m, r, 16'h1A5B)}, rd)
      end
    end
    lat <= 8'h00;
    for (m = 0; m < 3; m += 2) begin
      mk = (m == 2) ? 8'hFF : 8'hA5;
      apb(1'b1, 12'h000, 32'(m + 4));
      apb(1'b1, 12'h080, {24'h0, mk});
      t = n_conv;
      apb(1'b1, 12'h004, 32'h1);
      wt(t + 1, 1'b1);
      c = 0;
      for (i = 0; i < 8; i++) begin
        if (mk[i] && c < ((m == 2) ? 4 : 8)) begin
          `CHK("order", 3'(i), log_q[6'(t + c)])
          c++;
        end
      end
      `CHK("count", t + c, n_conv)
    end
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h084, 32'h02);
    apb(1'b1, 12'h088, 32'h10);
    t = n_conv;
    apb(1'b1, 12'h004, 32'h6);
    wt(t + 2, 1'b1);
    `CHK("low group", 3'h1, log_q[6'(t)])
    `CHK("next group", 3'h4, log_q[6'(t + 1)])
    `CHK("group", 4'h2, scan_group)
    apb(1'b1, 12'h08C, 32'h08);
    apb(1'b1, 12'h04C, 32'h14);
    t = n_conv;
    pulse(3);
    repeat (40) @(posedge sys_clk);
    `CHK("disabled trigger", t, n_conv)
    apb(1'b1, 12'h008, 32'h08);
    pulse(3);
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      if (conv_start === 1'b1) break;
    end
    `CHK("delay", 1'b1, i >= 20 && i <= 32)
    wt(t + 1, 1'b1);
    ext_trig_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_trig_n <= 1'b1;
    wt(t + 2, 1'b1);
    `CHK("external", 3'h3, log_q[6'(t + 1)])
    apb(1'b1, 12'h004, 32'h08);
    wt(t + 3, 1'b1);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h14);
    apb(1'b1, 12'h080, 32'h03);
    t = n_conv;
    apb(1'b1, 12'h004, 32'h1);
    wt(t + 6, 1'b0);
    apb(1'b1, 12'h000, 32'h114);
    wt(0, 1'b1);
    t = n_conv;
    repeat (50) @(posedge sys_clk);
    `CHK("stopped", t, n_conv)
    apb(1'b1, 12'h000, 32'h24);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("mode", 2'h1, rd[5:4])
    apb(1'b1, 12'h000, 32'h2E);
    apb(1'b1, 12'h040, 32'h0);
    apb(1'b1, 12'h008, 32'h01);
    apb(1'b0, 12'h0C0, 32'h0);
    old = rd;
    p = pub_cnt;
    t = n_conv;
    apb(1'b1, 12'h004, 32'h1);
    wt(t + 4, 1'b0);
    apb(1'b0, 12'h0C0, 32'h0);
    `CHK("held", old, rd)
    pulse(0);
    repeat (3) @(posedge sys_clk);
    pulse(0);
    repeat (12) @(posedge sys_clk);
    pulse(0);
    repeat (6) @(posedge sys_clk);
    `CHK("publish count", p + 2, pub_cnt)
    apb(1'b0, 12'h0C0, 32'h0);
    `CHK("published", 32'h1A5B, rd)
    apb(1'b1, 12'h000, 32'h12E);
    wt(0, 1'b1);
    print_verdict();
  end
endmodule : asms_top_tb
`default_nettype wire
